// ==== logic/mxe_pkg.sv ====
// Package for the skip/subtract/swap/table/xor execution slice.
// Assumes a single system clock and an APB register bus.
package mxe_pkg;
   // ==========================================
   // Register byte offsets
   localparam logic [7:0] MXE_OFF_CTRL   = 8'h00;
   localparam logic [7:0] MXE_OFF_WORK   = 8'h04;
   localparam logic [7:0] MXE_OFF_FLAGS  = 8'h08;
   localparam logic [7:0] MXE_OFF_TPTR   = 8'h0c;
   localparam logic [7:0] MXE_OFF_THIGH  = 8'h10;
   localparam logic [7:0] MXE_OFF_STAT   = 8'h14;
   localparam logic [7:0] MXE_OFF_MADDR  = 8'h18;
   localparam logic [7:0] MXE_OFF_MDATA  = 8'h1c;
   localparam logic [7:0] MXE_OFF_PCPAGE = 8'h20;
   // ==========================================
   // Control word field positions
   localparam int MXE_CTRL_OP_LSB  = 0;
   localparam int MXE_CTRL_BIT_LSB = 8;
   localparam int MXE_CTRL_ADR_LSB = 16;
   localparam int MXE_CTRL_IMM_LSB = 24;
   // Flag positions in the flag register
   localparam int MXE_FLG_C  = 0;
   localparam int MXE_FLG_AC = 1;
   localparam int MXE_FLG_Z  = 2;
   localparam int MXE_FLG_OV = 3;
   // ==========================================
   // Reset values
   localparam logic [7:0] MXE_WORK_RST  = 8'h00;
   localparam logic [3:0] MXE_FLAGS_RST = 4'h0;
   localparam logic [7:0] MXE_TPTR_RST  = 8'h00;
   localparam logic [6:0] MXE_THIGH_RST = 7'h00;
   localparam logic [3:0] MXE_PAGE_RST  = 4'h0;
   // Cycle counts of an instruction
   localparam logic [1:0] MXE_CYC_SKIP   = 2'h2;
   localparam logic [1:0] MXE_CYC_NOSKIP = 2'h1;
   // ==========================================
   // Operations
   typedef enum logic [4:0] {
      MXE_OP_NOP       = 5'h00,
      MXE_OP_DEC_W_SZ  = 5'h01,
      MXE_OP_SET_BYTE  = 5'h02,
      MXE_OP_SET_BIT   = 5'h03,
      MXE_OP_INC_SZ    = 5'h04,
      MXE_OP_INC_W_SZ  = 5'h05,
      MXE_OP_SKIP_BSET = 5'h06,
      MXE_OP_SUB       = 5'h07,
      MXE_OP_SUB_M     = 5'h08,
      MXE_OP_SUB_IMM   = 5'h09,
      MXE_OP_SWAP      = 5'h0a,
      MXE_OP_SWAP_W    = 5'h0b,
      MXE_OP_SKIP_Z    = 5'h0c,
      MXE_OP_LOAD_SZ   = 5'h0d,
      MXE_OP_SKIP_BCLR = 5'h0e,
      MXE_OP_TRD_CUR   = 5'h0f,
      MXE_OP_TRD_LAST  = 5'h10,
      MXE_OP_XOR       = 5'h11,
      MXE_OP_XOR_M     = 5'h12
   } mxe_op_t;
endpackage

// ==== logic/mxe_dmem.sv ====
// Data memory of the slice: one write port, registered read data.
// Assumes the caller holds the address for one cycle before using data.
`timescale 1ns/1ps
module mxe_dmem #(
   parameter int AW = 8
) (
   // Clock
   input  wire logic          clk,
   // Access
   input  wire logic [AW-1:0] addr,
   input  wire logic          we,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   // ==========================================
   // Write then registered read
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// ==== logic/mxe_prom.sv ====
// Program memory for table reads: 15-bit words, registered read.
// Assumes contents are filled through the write port before use.
`timescale 1ns/1ps
module mxe_prom #(
   parameter int AW = 12
) (
   // Clock
   input  wire logic          clk,
   // Access
   input  wire logic [AW-1:0] addr,
   input  wire logic          we,
   input  wire logic [14:0]   wdata,
   output logic      [14:0]   rdata
);
   logic [14:0] mem [0:(1<<AW)-1];

   // ==========================================
   // Write then registered read
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// ==== logic/mxe_exec.sv ====
// Execution slice: skip, set, subtract, swap, table read and xor ops.
// Assumes an APB master on CLK_SYS; no other bus master touches memory.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module mxe_exec
   import mxe_pkg::*;
#(
   parameter int DAW = 8,
   parameter int PAW = 12,
   parameter int PGW = 4
) (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        ARST_N,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Pipeline view
   output logic             SKIP_DISCARD,
   output logic             BUSY
);
   import mxe_pkg::*;

   localparam int OFFW = PAW - PGW;

   typedef enum logic [2:0] {
      MXE_S_IDLE, MXE_S_READ, MXE_S_EXEC, MXE_S_TREAD, MXE_S_TWRITE, MXE_S_DUMMY
   } mxe_state_t;

   mxe_state_t state;
   mxe_op_t    op;
   logic [2:0]      bit_sel;
   logic [DAW-1:0]  m_addr;
   logic [7:0]      imm;
   logic [7:0]      working_register;
   logic [7:0]      table_pointer;
   logic [6:0]      table_high_byte_reg;
   logic            signed_wrap_flag;
   logic            aux_carry_flag;
   logic            zero_flag;
   logic            carry_flag;
   logic [PGW-1:0]  pc_page;
   logic [1:0]      last_cycles;
   logic            last_skip;
   logic [DAW-1:0]  sw_addr;

   // Memory ports
   logic [DAW-1:0]  dm_addr;
   logic            dm_we;
   logic [7:0]      dm_wdata;
   logic [7:0]      dm_rdata;
   logic [PAW-1:0]  pm_addr;
   logic            pm_we;
   logic [14:0]     pm_rdata;

   // APB decode
   logic apb_wr;
   logic apb_rd;
   logic busy_now;
   assign apb_wr   = PSEL && PENABLE && PWRITE && PREADY;
   assign apb_rd   = PSEL && PENABLE && !PWRITE && PREADY;
   assign busy_now = (state != MXE_S_IDLE);

   // ==========================================
   // Arithmetic helpers
   function automatic logic [7:0] swap_nib(input logic [7:0] v);
      swap_nib = {v[3:0], v[7:4]};
   endfunction

   // Complement addition a + ~b + 1 returning {ov, ac, c, result}
   function automatic logic [10:0] sub_calc(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] full;
      logic [4:0] low;
      logic [7:0] nb;
      nb   = ~b;
      full = {1'b0, a} + {1'b0, nb} + 9'h001;
      low  = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + 5'h01;
      sub_calc = {(a[7] == nb[7]) && (full[7] != a[7]), low[4], full[8], full[7:0]};
   endfunction

   // ==========================================
   // Execute-stage combinational results
   logic [7:0]  m_val;
   logic [10:0] sub_res;
   logic [7:0]  inc_val;
   logic [7:0]  dec_val;
   logic [7:0]  set_bit_val;
   logic        take_skip;
   assign m_val       = dm_rdata;
   assign sub_res     = sub_calc(working_register, (op == MXE_OP_SUB_IMM) ? imm : m_val);
   assign inc_val     = m_val + 8'h01;
   assign dec_val     = m_val - 8'h01;
   assign set_bit_val = m_val | (8'h01 << bit_sel);

   always_comb begin
      take_skip = 1'b0;
      case (op)
         MXE_OP_DEC_W_SZ:  take_skip = (dec_val == 8'h00);
         MXE_OP_INC_SZ:    take_skip = (inc_val == 8'h00);
         MXE_OP_INC_W_SZ:  take_skip = (inc_val == 8'h00);
         MXE_OP_SKIP_BSET: take_skip = m_val[bit_sel];
         MXE_OP_SKIP_Z:    take_skip = (m_val == 8'h00);
         MXE_OP_LOAD_SZ:   take_skip = (m_val == 8'h00);
         MXE_OP_SKIP_BCLR: take_skip = !m_val[bit_sel];
         default:          take_skip = 1'b0;
      endcase
   end

   // ==========================================
   // Data memory port steering: sequencer has priority over software
   always_comb begin
      dm_addr  = busy_now ? m_addr : sw_addr;
      dm_we    = 1'b0;
      dm_wdata = 8'h00;
      if (state == MXE_S_EXEC) begin
         case (op)
            MXE_OP_SET_BYTE: begin
               dm_we    = 1'b1;
               dm_wdata = 8'hff;
            end
            MXE_OP_SET_BIT: begin
               dm_we    = 1'b1;
               dm_wdata = set_bit_val;
            end
            MXE_OP_INC_SZ: begin
               dm_we    = 1'b1;
               dm_wdata = inc_val;
            end
            MXE_OP_SUB_M: begin
               dm_we    = 1'b1;
               dm_wdata = sub_res[7:0];
            end
            MXE_OP_SWAP: begin
               dm_we    = 1'b1;
               dm_wdata = swap_nib(m_val);
            end
            MXE_OP_XOR_M: begin
               dm_we    = 1'b1;
               dm_wdata = working_register ^ m_val;
            end
            default: begin
               dm_we    = 1'b0;
               dm_wdata = 8'h00;
            end
         endcase
      end else if (state == MXE_S_TWRITE) begin
         dm_we    = 1'b1;
         dm_wdata = pm_rdata[7:0];
      end else if (!busy_now && apb_wr && PADDR == MXE_OFF_MDATA) begin
         dm_we    = 1'b1;
         dm_wdata = PWDATA[7:0];
      end
   end

   // Program memory: table reads choose page, software may load words
   always_comb begin
      pm_we   = 1'b0;
      pm_addr = {pc_page, table_pointer[OFFW-1:0]};
      if (op == MXE_OP_TRD_LAST) begin
         pm_addr = {{PGW{1'b1}}, table_pointer[OFFW-1:0]};
      end
      if (!busy_now && apb_wr && PADDR == MXE_OFF_THIGH) begin
         pm_we   = 1'b1;
         pm_addr = PWDATA[16 +: PAW];
      end
   end

   mxe_dmem #(.AW(DAW)) u_dmem (
      .clk   (CLK_SYS),
      .addr  (dm_addr),
      .we    (dm_we),
      .wdata (dm_wdata),
      .rdata (dm_rdata)
   );

   mxe_prom #(.AW(PAW)) u_prom (
      .clk   (CLK_SYS),
      .addr  (pm_addr),
      .we    (pm_we),
      .wdata (PWDATA[14:0]),
      .rdata (pm_rdata)
   );

   // ==========================================
   // Instruction sequencer
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= MXE_S_IDLE;
      end else begin
         case (state)
            MXE_S_IDLE:   if (apb_wr && PADDR == MXE_OFF_CTRL) state <= MXE_S_READ;
            MXE_S_READ:   state <= (op == MXE_OP_TRD_CUR || op == MXE_OP_TRD_LAST) ?
                                   MXE_S_TREAD : MXE_S_EXEC;
            MXE_S_EXEC:   state <= take_skip ? MXE_S_DUMMY : MXE_S_IDLE;
            MXE_S_TREAD:  state <= MXE_S_TWRITE;
            MXE_S_TWRITE: state <= MXE_S_IDLE;
            MXE_S_DUMMY:  state <= MXE_S_IDLE;
            default:      state <= MXE_S_IDLE;
         endcase
      end
   end

   // Command capture
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         op      <= MXE_OP_NOP;
         bit_sel <= 3'h0;
         m_addr  <= '0;
         imm     <= 8'h00;
      end else if (!busy_now && apb_wr && PADDR == MXE_OFF_CTRL) begin
         op      <= mxe_op_t'(PWDATA[MXE_CTRL_OP_LSB +: 5]);
         bit_sel <= PWDATA[MXE_CTRL_BIT_LSB +: 3];
         m_addr  <= PWDATA[MXE_CTRL_ADR_LSB +: DAW];
         imm     <= PWDATA[MXE_CTRL_IMM_LSB +: 8];
      end
   end

   // Working register: executed ops win over software writes
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         working_register <= MXE_WORK_RST;
      end else if (state == MXE_S_EXEC) begin
         case (op)
            MXE_OP_DEC_W_SZ: working_register <= dec_val;
            MXE_OP_INC_W_SZ: working_register <= inc_val;
            MXE_OP_SUB:      working_register <= sub_res[7:0];
            MXE_OP_SUB_IMM:  working_register <= sub_res[7:0];
            MXE_OP_SWAP_W:   working_register <= swap_nib(m_val);
            MXE_OP_LOAD_SZ:  working_register <= m_val;
            MXE_OP_XOR:      working_register <= working_register ^ m_val;
            default:         working_register <= working_register;
         endcase
      end else if (!busy_now && apb_wr && PADDR == MXE_OFF_WORK) begin
         working_register <= PWDATA[7:0];
      end
   end

   // Status flags: only subtract and xor touch them
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         {signed_wrap_flag, zero_flag, aux_carry_flag, carry_flag} <= MXE_FLAGS_RST;
      end else if (state == MXE_S_EXEC &&
                   (op == MXE_OP_SUB || op == MXE_OP_SUB_M || op == MXE_OP_SUB_IMM)) begin
         signed_wrap_flag <= sub_res[10];
         aux_carry_flag   <= sub_res[9];
         carry_flag       <= sub_res[8];
         zero_flag        <= (sub_res[7:0] == 8'h00);
      end else if (state == MXE_S_EXEC && (op == MXE_OP_XOR || op == MXE_OP_XOR_M)) begin
         zero_flag        <= ((working_register ^ m_val) == 8'h00);
      end else if (!busy_now && apb_wr && PADDR == MXE_OFF_FLAGS) begin
         carry_flag       <= PWDATA[MXE_FLG_C];
         aux_carry_flag   <= PWDATA[MXE_FLG_AC];
         zero_flag        <= PWDATA[MXE_FLG_Z];
         signed_wrap_flag <= PWDATA[MXE_FLG_OV];
      end
   end

   // Table pointer, page and table high byte
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         table_pointer       <= MXE_TPTR_RST;
         table_high_byte_reg <= MXE_THIGH_RST;
         pc_page             <= MXE_PAGE_RST;
         sw_addr             <= '0;
      end else begin
         if (state == MXE_S_TWRITE) begin
            table_high_byte_reg <= pm_rdata[14:8];
         end
         if (!busy_now && apb_wr && PADDR == MXE_OFF_TPTR) table_pointer <= PWDATA[7:0];
         if (!busy_now && apb_wr && PADDR == MXE_OFF_PCPAGE) pc_page <= PWDATA[PGW-1:0];
         if (!busy_now && apb_wr && PADDR == MXE_OFF_MADDR) sw_addr <= PWDATA[DAW-1:0];
      end
   end

   // Skip result and cycle count of the last instruction
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         last_skip    <= 1'b0;
         last_cycles  <= 2'h0;
         SKIP_DISCARD <= 1'b0;
         BUSY         <= 1'b0;
      end else begin
         SKIP_DISCARD <= (state == MXE_S_EXEC) && take_skip;
         BUSY         <= (state != MXE_S_IDLE) ? !(state == MXE_S_DUMMY ||
                         state == MXE_S_TWRITE || (state == MXE_S_EXEC && !take_skip))
                         : (apb_wr && PADDR == MXE_OFF_CTRL);
         if (state == MXE_S_EXEC) begin
            last_skip   <= take_skip;
            last_cycles <= take_skip ? MXE_CYC_SKIP : MXE_CYC_NOSKIP;
         end else if (state == MXE_S_TWRITE) begin
            last_skip   <= 1'b0;
            last_cycles <= MXE_CYC_SKIP;
         end
      end
   end

   // ==========================================
   // APB answer: zero wait, reads registered at the edge that ends the setup phase
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         PRDATA  <= 32'h0000_0000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && (PADDR[1:0] != 2'h0 || PADDR > MXE_OFF_PCPAGE);
         if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
               MXE_OFF_CTRL:   PRDATA <= {imm, 8'(m_addr), 5'h00, bit_sel,
                                          3'h0, op};
               MXE_OFF_WORK:   PRDATA <= {24'h0, working_register};
               MXE_OFF_FLAGS:  PRDATA <= {28'h0, signed_wrap_flag, zero_flag,
                                          aux_carry_flag, carry_flag};
               MXE_OFF_TPTR:   PRDATA <= {24'h0, table_pointer};
               MXE_OFF_THIGH:  PRDATA <= {25'h0, table_high_byte_reg};
               MXE_OFF_STAT:   PRDATA <= {28'h0, last_cycles, last_skip, busy_now};
               MXE_OFF_MADDR:  PRDATA <= {{(32-DAW){1'b0}}, sw_addr};
               MXE_OFF_MDATA:  PRDATA <= {24'h0, dm_rdata};
               MXE_OFF_PCPAGE: PRDATA <= {{(32-PGW){1'b0}}, pc_page};
               default:        PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ==== sim/mxe_exec_chk.sv ====
// Checker for the execution slice: bus handshake and skip timing.
// Assumes it is bound to mxe_exec and sees only that module's ports.
`timescale 1ns/1ps
module mxe_exec_chk (
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        ARST_N,
   // APB
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // Pipeline view
   input wire logic        SKIP_DISCARD,
   input wire logic        BUSY
);
   // ==========================================
   // Cycles since a control write, and length of the busy run
   logic [3:0] since_ctrl;
   logic [3:0] busy_run;
   logic       bad_addr;
   assign bad_addr = (PADDR > 8'h20) || (PADDR[1:0] != 2'h0);
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N)
         since_ctrl <= 4'hf;
      else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00)
         since_ctrl <= 4'h0;
      else if (since_ctrl != 4'hf)
         since_ctrl <= since_ctrl + 4'h1;
   end
   // Saturates so a stuck busy keeps failing instead of wrapping
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N)
         busy_run <= 4'h0;
      else if (BUSY && busy_run != 4'hf)
         busy_run <= busy_run + 4'h1;
      else if (!BUSY)
         busy_run <= 4'h0;
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!ARST_N);
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_done;
      PSEL && PENABLE && PREADY;
   endsequence
   AST_READY_NEXT: assert property (s_setup |=> PREADY)
      else $error("no ready in access phase");
   AST_READY_ACCESS: assert property (PREADY |-> PSEL && PENABLE)
      else $error("ready outside access phase");
   AST_READY_ONE: assert property (s_done |=> !PREADY)
      else $error("ready longer than one cycle");
   AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   AST_ERR_BAD: assert property (s_done ##0 bad_addr |-> PSLVERR)
      else $error("unmapped access not flagged");
   AST_ERR_GOOD: assert property (s_done ##0 !bad_addr |-> !PSLVERR)
      else $error("mapped access flagged");
   AST_ERR_READ_ZERO: assert property (s_done ##0 PSLVERR && !PWRITE |-> PRDATA == 32'h0)
      else $error("unmapped read not zero");
   AST_SKIP_PULSE: assert property (SKIP_DISCARD |=> !SKIP_DISCARD)
      else $error("discard longer than one dummy cycle");
   AST_SKIP_CAUSE: assert property (SKIP_DISCARD |-> since_ctrl <= 4'h3)
      else $error("discard without a recent instruction");
   AST_BUSY_SHORT: assert property (BUSY |-> busy_run <= 4'h2)
      else $error("instruction busy too long");
endmodule
bind mxe_exec mxe_exec_chk u_chk (
   .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .SKIP_DISCARD(SKIP_DISCARD), .BUSY(BUSY)
);

// ==== sim/mxe_mem_ref.sv ====
// Expected data and program memory contents behind the slice.
// Assumes the bench mirrors every store it makes into these arrays.
`timescale 1ns/1ps
module mxe_mem_ref;
   // ==========================================
   // Expected contents, updated by the bench through hierarchy
   logic [7:0]  dm [256];
   logic [14:0] pm [4096];
   // Fetch address: last page is the all-ones page
   function automatic logic [11:0] taddr(input logic [3:0] pg, input logic [7:0] ptr,
                                         input logic last);
      return {(last ? 4'hf : pg), ptr};
   endfunction
endmodule

// ==== sim/mcu_skip_sub_swap_table_ops_tb_top.sv ====
// Self-checking bench for the execution slice over APB.
// Assumes mxe_exec, its checker bind and the memory reference model.
`timescale 1ns/1ps
module mcu_skip_sub_swap_table_ops_tb_top;
   import mxe_pkg::*;
   // ==========================================
   // Stimulus and observation
   logic        clk_sys = 1'b0;
   logic        arst_n  = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        skip_discard;
   logic        busy;
   logic [31:0] rd;
   logic        rerr;
   int          err_total = 0;
   int          compares  = 0;
   int          cycles    = 0;
   int          discards  = 0;
   int          busy_cyc  = 0;
   mxe_mem_ref ref_mem ();
   mxe_exec dut (
      .CLK_SYS(clk_sys), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .SKIP_DISCARD(skip_discard), .BUSY(busy)
   );
   // 25 MHz clock
   always #20 clk_sys = ~clk_sys;
   // Hang guard: whole run needs about a thousand cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         results();
      end
   end
   // Discard pulses and busy cycles, judged per instruction
   always @(posedge clk_sys) begin
      if (skip_discard === 1'b1)
         discards++;
      if (busy === 1'b1)
         busy_cyc++;
   end
   // ==========================================
   // Verdict
   task automatic results();
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // ==========================================
   // One APB transfer; an idle cycle after keeps drives one per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
      if (n >= 50)
         chk("pready", 32'h1, 32'h0);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wmem(input logic [7:0] a, input logic [7:0] v);
      apb(1'b1, MXE_OFF_MADDR, {24'h0, a});
      apb(1'b1, MXE_OFF_MDATA, {24'h0, v});
      ref_mem.dm[a] = v;
   endtask
   task automatic cmem(input logic [7:0] a);
      apb(1'b1, MXE_OFF_MADDR, {24'h0, a});
      apb(1'b0, MXE_OFF_MDATA, 32'h0);
      chk("mem", {24'h0, ref_mem.dm[a]}, rd);
   endtask
   task automatic creg(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   // Issue one instruction, poll busy; sk 2 means status not judged
   task automatic run(input mxe_op_t op, input logic [2:0] b, input logic [7:0] a,
                      input logic [7:0] imm, input logic [1:0] sk);
      int n;
      int d0;
      int b0;
      n = 0;
      d0 = discards;
      b0 = busy_cyc;
      apb(1'b1, MXE_OFF_CTRL, {imm, a, 5'h0, b, 3'h0, op});
      do apb(1'b0, MXE_OFF_STAT, 32'h0); while (rd[0] !== 1'b0 && ++n < 20);
      if (sk != 2'h2)
         chk("status", {28'h0, (sk[0] ? MXE_CYC_SKIP : MXE_CYC_NOSKIP), sk[0], 1'b0}, rd);
      chk("discard", {31'h0, sk == 2'h1}, 32'(discards - d0));
      chk("busy", (sk == 2'h0) ? 32'h2 : 32'h3, 32'(busy_cyc - b0));
   endtask
   // ==========================================
   // Scenarios
   task automatic t_dec_inc();
      apb(1'b1, MXE_OFF_FLAGS, 32'ha);
      wmem(8'h10, 8'h01);
      run(MXE_OP_DEC_W_SZ, 3'h0, 8'h10, 8'h00, 2'h1);
      creg("work", MXE_OFF_WORK, 32'h0);
      cmem(8'h10);
      wmem(8'h10, 8'h00);
      run(MXE_OP_DEC_W_SZ, 3'h0, 8'h10, 8'h00, 2'h0);
      creg("work", MXE_OFF_WORK, 32'hff);
      wmem(8'h11, 8'hff);
      run(MXE_OP_INC_SZ, 3'h0, 8'h11, 8'h00, 2'h1);
      ref_mem.dm[8'h11] = 8'h00;
      cmem(8'h11);
      run(MXE_OP_INC_SZ, 3'h0, 8'h11, 8'h00, 2'h0);
      ref_mem.dm[8'h11] = 8'h01;
      cmem(8'h11);
      wmem(8'h12, 8'hff);
      run(MXE_OP_INC_W_SZ, 3'h0, 8'h12, 8'h00, 2'h1);
      creg("work", MXE_OFF_WORK, 32'h0);
      cmem(8'h12);
      creg("flags", MXE_OFF_FLAGS, 32'ha);
   endtask
   task automatic t_set_swap();
      apb(1'b1, MXE_OFF_FLAGS, 32'h5);
      wmem(8'h20, 8'h12);
      run(MXE_OP_SET_BYTE, 3'h0, 8'h20, 8'h00, 2'h0);
      ref_mem.dm[8'h20] = 8'hff;
      cmem(8'h20);
      wmem(8'h21, 8'h01);
      run(MXE_OP_SET_BIT, 3'h7, 8'h21, 8'h00, 2'h0);
      ref_mem.dm[8'h21] = 8'h81;
      cmem(8'h21);
      wmem(8'h50, 8'h3c);
      run(MXE_OP_SWAP, 3'h0, 8'h50, 8'h00, 2'h0);
      ref_mem.dm[8'h50] = 8'hc3;
      cmem(8'h50);
      wmem(8'h51, 8'ha5);
      run(MXE_OP_SWAP_W, 3'h0, 8'h51, 8'h00, 2'h0);
      creg("work", MXE_OFF_WORK, 32'h5a);
      cmem(8'h51);
      creg("flags", MXE_OFF_FLAGS, 32'h5);
   endtask
   task automatic t_skips();
      wmem(8'h30, 8'h5a);
      wmem(8'h31, 8'h00);
      for (int i = 0; i < 8; i++) begin
         run(MXE_OP_SKIP_BSET, 3'(i), 8'h30, 8'h00, {1'b0, ref_mem.dm[8'h30][i]});
         run(MXE_OP_SKIP_BCLR, 3'(i), 8'h30, 8'h00, {1'b0, !ref_mem.dm[8'h30][i]});
      end
      run(MXE_OP_SKIP_Z, 3'h0, 8'h30, 8'h00, 2'h0);
      run(MXE_OP_SKIP_Z, 3'h0, 8'h31, 8'h00, 2'h1);
      run(MXE_OP_LOAD_SZ, 3'h0, 8'h30, 8'h00, 2'h0);
      creg("work", MXE_OFF_WORK, 32'h5a);
      run(MXE_OP_LOAD_SZ, 3'h0, 8'h31, 8'h00, 2'h1);
      creg("work", MXE_OFF_WORK, 32'h0);
      cmem(8'h30);
   endtask
   // Expected {result, OV, Z, AC, C} of the complement subtraction
   function automatic logic [11:0] subx(input logic [7:0] w, input logic [7:0] m);
      logic [8:0] s;
      logic [4:0] l;
      s = {1'b0, w} + {1'b0, ~m} + 9'h1;
      l = {1'b0, w[3:0]} + {1'b0, ~m[3:0]} + 5'h1;
      return {s[7:0], (w[7] == ~m[7]) && (s[7] != w[7]), s[7:0] == 8'h0, l[4], s[8]};
   endfunction
   task automatic t_sub();
      logic [7:0] pw [5] = '{8'h10, 8'h00, 8'h80, 8'h55, 8'h7f};
      logic [7:0] pv [5] = '{8'h01, 8'h01, 8'h01, 8'h55, 8'hff};
      mxe_op_t    so [3] = '{MXE_OP_SUB, MXE_OP_SUB_M, MXE_OP_SUB_IMM};
      logic [11:0] e;
      for (int i = 0; i < 5; i++) begin
         for (int k = 0; k < 3; k++) begin
            e = subx(pw[i], pv[i]);
            apb(1'b1, MXE_OFF_WORK, {24'h0, pw[i]});
            wmem(8'h40, (k == 2) ? 8'h33 : pv[i]);
            run(so[k], 3'h0, 8'h40, pv[i], 2'h0);
            if (k == 1)
               ref_mem.dm[8'h40] = e[11:4];
            creg("work", MXE_OFF_WORK, {24'h0, (k == 1) ? pw[i] : e[11:4]});
            cmem(8'h40);
            creg("flags", MXE_OFF_FLAGS, {28'h0, e[3:0]});
         end
      end
   endtask
   task automatic t_table();
      logic [11:0] ca;
      logic [11:0] la;
      ca = ref_mem.taddr(4'h3, 8'h44, 1'b0);
      la = ref_mem.taddr(4'h3, 8'h44, 1'b1);
      ref_mem.pm[ca] = 15'h2a5c;
      ref_mem.pm[la] = 15'h71e3;
      apb(1'b1, MXE_OFF_THIGH, {4'h0, ca, 1'b0, ref_mem.pm[ca]});
      apb(1'b1, MXE_OFF_THIGH, {4'h0, la, 1'b0, ref_mem.pm[la]});
      apb(1'b1, MXE_OFF_PCPAGE, 32'h3);
      apb(1'b1, MXE_OFF_TPTR, 32'h44);
      run(MXE_OP_TRD_CUR, 3'h0, 8'h60, 8'h00, 2'h2);
      ref_mem.dm[8'h60] = ref_mem.pm[ca][7:0];
      cmem(8'h60);
      creg("thigh", MXE_OFF_THIGH, {25'h0, ref_mem.pm[ca][14:8]});
      run(MXE_OP_TRD_LAST, 3'h0, 8'h61, 8'h00, 2'h2);
      ref_mem.dm[8'h61] = ref_mem.pm[la][7:0];
      cmem(8'h61);
      creg("thigh", MXE_OFF_THIGH, {25'h0, ref_mem.pm[la][14:8]});
   endtask
   task automatic t_xor_bus();
      apb(1'b1, MXE_OFF_FLAGS, 32'hb);
      apb(1'b1, MXE_OFF_WORK, 32'h5a);
      wmem(8'h70, 8'h5a);
      run(MXE_OP_XOR, 3'h0, 8'h70, 8'h00, 2'h0);
      creg("work", MXE_OFF_WORK, 32'h0);
      creg("flags", MXE_OFF_FLAGS, 32'hf);
      apb(1'b1, MXE_OFF_WORK, 32'h33);
      wmem(8'h71, 8'h0f);
      run(MXE_OP_XOR_M, 3'h0, 8'h71, 8'h00, 2'h0);
      ref_mem.dm[8'h71] = 8'h3c;
      cmem(8'h71);
      creg("flags", MXE_OFF_FLAGS, 32'hb);
      apb(1'b0, 8'h24, 32'h0);
      chk("slverr", 32'h1, {31'h0, rerr});
      apb(1'b1, 8'h06, 32'h0);
      chk("slverr", 32'h1, {31'h0, rerr});
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      t_dec_inc();
      t_set_swap();
      t_skips();
      t_sub();
      t_table();
      t_xor_bus();
      results();
   end
endmodule
